// [inc/boot_remap_pkg.sv]
// constants for the boot remap address decoder
// What this block does
// - split 32-bit space into sixteen 256 MB banks by top four address bits
// - banks one to eight go to external bus interface, chip selects 0..5
// - bank zero holds internal memories; second level gives a 1 MB area
// - bank fifteen goes to the peripheral bridge for the APB
// - access to an unused area is aborted back to its master
// - address zero mapping chosen per master from remap bit and boot select
// - window 0x0..0x000F_FFFF is the boot window, fixed by strap at reset
// - remap clear, strap high: boot window aliases internal ROM
// - remap clear, strap low: boot window goes to external chip select zero
// - internal ROM always answers at 0x0040_0000
// - every memory stays at its fixed base; remap only changes address zero
// - SRAM only at 0x0030_0000 before remap; after, also at zero for cpu masters
// - 64 KB SRAM is four 16 KB blocks shared among three regions
// - TCM sizes 0, 16 or 32 KB each; AHB region takes the rest
// - instruction TCM region also reachable over AHB at 0x0010_0000
// - data TCM region also reachable over AHB at 0x0020_0000
// - fixed block order for TCMs; AHB region stacks rest descending
// - after reset both TCM sizes are zero
// - SRAM answers AHB accesses in a single cycle
package boot_remap_pkg;
    localparam int ADDR_W = 32;
    localparam int NUM_MASTERS = 6;
    localparam int MASTER_W = 3;
    localparam int BANK_LSB = 28;
    localparam logic [3:0] BANK_INTERNAL = 4'h0;
    localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
    localparam logic [3:0] BANK_EXT_LAST = 4'h8;
    localparam logic [3:0] BANK_PERIPH = 4'hF;
    localparam int AREA_LSB = 20;
    localparam logic [7:0] AREA_BOOT = 8'h00;
    localparam logic [7:0] AREA_INSTR_TCM = 8'h01;
    localparam logic [7:0] AREA_DATA_TCM = 8'h02;
    localparam logic [7:0] AREA_SRAM = 8'h03;
    localparam logic [7:0] AREA_ROM = 8'h04;
    localparam int ROM_AW = 15;
    localparam int BLK_LSB = 14;
    localparam int BLK_AW = 14;
    localparam int MASTER_CPU_INSTR = 4;
    localparam int MASTER_CPU_DATA = 5;
    localparam logic [1:0] TCM_0K = 2'h0;
    localparam logic [1:0] TCM_16K = 2'h1;
    localparam logic [1:0] TCM_32K = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HRESP_ERROR = 2'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_ROM = 3'b001,
        TGT_SRAM = 3'b010,
        TGT_EXT = 3'b011,
        TGT_PERIPH = 3'b100
    } target_t;
endpackage

// [core/sram_block_map.sv]
// maps an internal sram area offset onto one of the four 16 KB blocks
`timescale 1ns/10ps
module sram_block_map
    import boot_remap_pkg::*;
(
    input wire logic [1:0] area_sel,
    input wire logic [1:0] slot,
    input wire logic [1:0] instr_tcm_size,
    input wire logic [1:0] data_tcm_size,
    output logic hit,
    output logic [1:0] block
);
    logic [2:0] i_cnt;
    logic [2:0] d_cnt;
    logic [2:0] c_cnt;
    logic [2:0] rest_idx;
    logic [3:0] free_mask;

    // number of 16 KB blocks that a tcm size code claims
    function automatic logic [2:0] blocks_of(input logic [1:0] size);
        blocks_of = (size == TCM_32K) ? 3'd2 : (size == TCM_16K) ? 3'd1 : 3'd0;
    endfunction

    // block counts per region, ahb region gets the rest
    always_comb begin
        i_cnt = blocks_of(instr_tcm_size);
        d_cnt = blocks_of(data_tcm_size);
        c_cnt = 3'd4 - i_cnt - d_cnt;
        // one bit per block not claimed by either tcm
        free_mask = {d_cnt == 3'd0, d_cnt < 3'd2, i_cnt == 3'd0, i_cnt < 3'd2};
        rest_idx = 3'd0;
        hit = 1'b0;
        block = 2'd0;
        case (area_sel)
            2'd1: begin
                // instruction tcm takes block one then block zero
                hit = {1'b0, slot} < i_cnt;
                block = (slot == 2'd0) ? 2'd1 : 2'd0;
            end
            2'd2: begin
                // data tcm takes block three then block two
                hit = {1'b0, slot} < d_cnt;
                block = (slot == 2'd0) ? 2'd3 : 2'd2;
            end
            2'd3: begin
                // ahb region walks free blocks from three down, rest_idx counts them
                hit = {1'b0, slot} < c_cnt;
                for (int b = 3; b >= 0; b--) begin
                    if (free_mask[b]) begin
                        if (rest_idx == {1'b0, slot}) begin
                            block = 2'(b);
                        end
                        rest_idx = rest_idx + 3'd1;
                    end
                end
            end
            default: begin
                hit = 1'b0;
                block = 2'd0;
            end
        endcase
    end
endmodule

// [core/boot_remap_address_decoder.sv]
// first and second level address decoder with boot remap and sram banking
`timescale 1ns/10ps
module boot_remap_address_decoder
    import boot_remap_pkg::*;
#(
    parameter int N_MASTERS = NUM_MASTERS
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic boot_select_pin,
    input wire logic [N_MASTERS-1:0] master_remap_bit,
    input wire logic [1:0] instr_tcm_size,
    input wire logic [1:0] data_tcm_size,
    input wire logic [MASTER_W-1:0] req_master,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hready,
    output logic [1:0] hresp,
    output logic sel_rom,
    output logic sel_sram,
    output logic sel_ext,
    output logic sel_periph,
    output logic [2:0] ext_chip_select,
    output logic [ADDR_W-1:0] slave_addr,
    output logic boot_from_rom
);
    ////////////////////////////////////////////////////////////////////////////
    // strap capture

    logic strap_meta_reg;
    logic strap_sync_reg;
    logic strap_taken_reg;
    logic boot_rom_reg;
    logic [1:0] instr_tcm_size_reg;
    logic [1:0] data_tcm_size_reg;

    // two-stage sync of the pin, free running so it tracks the strap during reset
    always_ff @(posedge core_clk) begin
        strap_meta_reg <= boot_select_pin;
        strap_sync_reg <= strap_meta_reg;
    end

    // latch the strap once after reset release
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strap_taken_reg <= 1'b0;
            boot_rom_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            boot_rom_reg <= strap_sync_reg;
        end
    end

    assign boot_from_rom = boot_rom_reg;

    // tcm size config, both zero after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            instr_tcm_size_reg <= TCM_0K;
            data_tcm_size_reg <= TCM_0K;
        end else begin
            instr_tcm_size_reg <= (instr_tcm_size > TCM_32K) ? TCM_32K : instr_tcm_size;
            data_tcm_size_reg <= (data_tcm_size > TCM_32K) ? TCM_32K : data_tcm_size;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [3:0] bank;
    logic [7:0] area;
    logic remap_on;
    logic cpu_master;
    logic active;
    target_t tgt;
    logic [1:0] sram_area;
    logic [1:0] sram_slot;
    logic blk_hit;
    logic [1:0] blk_idx;

    assign bank = haddr[ADDR_W-1:BANK_LSB];
    assign area = haddr[BANK_LSB-1:AREA_LSB];
    assign active = htrans[1];
    assign remap_on = master_remap_bit[req_master];
    assign cpu_master = (req_master == MASTER_W'(MASTER_CPU_INSTR))
        || (req_master == MASTER_W'(MASTER_CPU_DATA));
    assign sram_slot = haddr[BLK_LSB+1:BLK_LSB];

    // choose target and sram area from address and remap state
    always_comb begin
        tgt = TGT_NONE;
        sram_area = 2'd0;
        if (bank == BANK_INTERNAL) begin
            if (area == AREA_BOOT) begin
                if (remap_on && cpu_master) begin
                    tgt = TGT_SRAM;
                    sram_area = 2'd3;
                end else if (remap_on) begin
                    tgt = TGT_NONE;
                end else if (boot_rom_reg) begin
                    tgt = TGT_ROM;
                end else begin
                    tgt = TGT_EXT;
                end
            end else if (area == AREA_INSTR_TCM) begin
                tgt = TGT_SRAM;
                sram_area = 2'd1;
            end else if (area == AREA_DATA_TCM) begin
                tgt = TGT_SRAM;
                sram_area = 2'd2;
            end else if (area == AREA_SRAM) begin
                tgt = TGT_SRAM;
                sram_area = 2'd3;
            end else if (area == AREA_ROM) begin
                tgt = TGT_ROM;
            end else begin
                tgt = TGT_NONE;
            end
        end else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST) begin
            tgt = TGT_EXT;
        end else if (bank == BANK_PERIPH) begin
            tgt = TGT_PERIPH;
        end else begin
            tgt = TGT_NONE;
        end
    end

    sram_block_map u_map (
        .area_sel(sram_area),
        .slot(sram_slot),
        .instr_tcm_size(instr_tcm_size_reg),
        .data_tcm_size(data_tcm_size_reg),
        .hit(blk_hit),
        .block(blk_idx)
    );

    // chip select index for external banks, 1..6 map to 0..5
    function automatic logic [2:0] ext_cs(input logic [3:0] b);
        logic [3:0] idx;
        idx = (b == BANK_INTERNAL) ? 4'h0 : b - 4'h1;
        ext_cs = (idx > 4'h5) ? 3'h5 : idx[2:0];
    endfunction

    logic sram_ok;
    logic hit_any;
    assign sram_ok = (tgt == TGT_SRAM) && blk_hit;
    assign hit_any = (tgt == TGT_ROM) || sram_ok || (tgt == TGT_EXT) || (tgt == TGT_PERIPH);

    // slave selects, none for an unmapped access
    assign sel_rom = active && (tgt == TGT_ROM);
    assign sel_sram = active && sram_ok;
    assign sel_ext = active && (tgt == TGT_EXT);
    assign sel_periph = active && (tgt == TGT_PERIPH);
    assign ext_chip_select = ext_cs(bank);
    assign slave_addr = haddr;

    ////////////////////////////////////////////////////////////////////////////
    // internal sram, four blocks

    logic [31:0] ram_mem [0:4*(1<<(BLK_AW-2))-1];
    logic [BLK_AW-3:0] word_idx;
    logic [BLK_AW-1:0] ram_idx;
    logic wr_pend_reg;
    logic [BLK_AW-1:0] wr_addr_reg;
    logic err_pend_reg;
    logic err_phase_reg;

    assign word_idx = haddr[BLK_LSB-1:2];
    assign ram_idx = {blk_idx, word_idx};

    // address phase capture for sram writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= sel_sram && hwrite;
            wr_addr_reg <= ram_idx;
        end
    end

    // sram write in data phase
    always_ff @(posedge core_clk) begin
        if (wr_pend_reg) begin
            ram_mem[wr_addr_reg] <= hwdata;
        end
    end

    // read data from flip-flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (sel_sram && !hwrite) begin
            // a read right behind a write to the same word takes the write data
            if (wr_pend_reg && wr_addr_reg == ram_idx) begin
                hrdata <= hwdata;
            end else begin
                hrdata <= ram_mem[ram_idx];
            end
        end
    end

    // two-cycle error response
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            err_pend_reg <= 1'b0;
            err_phase_reg <= 1'b0;
        end else begin
            err_pend_reg <= active && !hit_any && !err_pend_reg;
            err_phase_reg <= err_pend_reg;
        end
    end

    assign hready = !err_pend_reg;
    assign hresp = (err_pend_reg || err_phase_reg) ? HRESP_ERROR : HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // the two cycles of an error response
    sequence s_err_first;
        hresp == HRESP_ERROR && !hready;
    endsequence

    sequence s_err_second;
        hresp == HRESP_ERROR && hready;
    endsequence

    a_unmapped_error: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && !hit_any && !err_pend_reg |=> s_err_first ##1 s_err_second)
        else $error("unmapped access not errored");

    a_error_no_select: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && !hit_any |-> !sel_rom && !sel_sram && !sel_ext && !sel_periph)
        else $error("unmapped access selected a slave");

    a_one_select: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $onehot0({sel_rom, sel_sram, sel_ext, sel_periph}))
        else $error("more than one slave selected");

    a_ext_banks: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && bank >= 4'h1 && bank <= 4'h8 |-> sel_ext && !sel_rom)
        else $error("external bank not routed");

    a_periph_bank: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && bank == 4'hF |-> sel_periph)
        else $error("bank 15 not to bridge");

    a_rom_fixed: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:20] == 12'h004 |-> sel_rom)
        else $error("rom base lost");

    a_boot_rom: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:20] == 12'h000 && !remap_on && boot_rom_reg |-> sel_rom)
        else $error("boot window not rom");

    a_boot_ext: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:20] == 12'h000 && !remap_on && !boot_rom_reg
        |-> sel_ext && ext_chip_select == 3'h0)
        else $error("boot window not cs0");

    a_strap_hold: assert property (
        @(posedge core_clk) disable iff (!nrst)
        strap_taken_reg |=> $stable(boot_rom_reg))
        else $error("strap changed");

    a_sram_one_cycle: assert property (
        @(posedge core_clk) disable iff (!nrst)
        sel_sram && !hwrite |=> hready && hresp == HRESP_OKAY)
        else $error("sram not single cycle");

    a_remap_sram: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:20] == 12'h000 && remap_on && cpu_master
        |-> sel_sram == blk_hit && !sel_rom && !sel_ext)
        else $error("remap sram missing");

    a_sram_base_block: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:14] == 18'h0_00C0 && data_tcm_size_reg == TCM_0K
        |-> sel_sram && blk_idx == 2'd3)
        else $error("ahb sram base not on block three");

    a_instr_tcm_area: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:14] == 18'h0_0040 && instr_tcm_size_reg != TCM_0K
        |-> sel_sram && blk_idx == 2'd1)
        else $error("instruction tcm area not on block one");

    a_data_tcm_area: assert property (
        @(posedge core_clk) disable iff (!nrst)
        active && haddr[31:14] == 18'h0_0080 && data_tcm_size_reg != TCM_0K
        |-> sel_sram && blk_idx == 2'd3)
        else $error("data tcm area not on block three");

    a_reset_tcm: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(strap_taken_reg)
        |-> $past(instr_tcm_size_reg) == TCM_0K && $past(data_tcm_size_reg) == TCM_0K)
        else $error("tcm not zero at reset");
endmodule

// [dv/ahb_master_model.sv]
// behavioural bus master that issues address and data phases
`timescale 1ns/10ps
module ahb_master_model
    import boot_remap_pkg::*;
(
    input wire logic core_clk,
    output logic [MASTER_W-1:0] req_master,
    output logic [ADDR_W-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata
);
    // idle bus at time zero
    initial begin
        req_master = '0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
    end

    // address phase, write data of the last cycle no longer valid
    task automatic start(input logic [2:0] m, input logic [31:0] a, input logic w);
        @(posedge core_clk);
        req_master <= m;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hwdata <= ~hwdata;
    endtask

    // data phase, address released to a changing pattern
    task automatic finish(input logic [31:0] d);
        @(posedge core_clk);
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= d;
        haddr <= ~haddr;
    endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the boot remap address decoder
`timescale 1ns/10ps
module testbench;
    import boot_remap_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic boot_select_pin = 1'b1;
    logic [5:0] master_remap_bit = 6'h00;
    logic [1:0] instr_tcm_size = TCM_0K;
    logic [1:0] data_tcm_size = TCM_0K;
    logic [2:0] req_master;
    logic [31:0] haddr, hwdata, hrdata, slave_addr;
    logic [1:0] htrans, hresp;
    logic hwrite, hready, sel_rom, sel_sram, sel_ext, sel_periph, boot_from_rom;
    logic [2:0] ext_chip_select;
    int n_fail = 0;
    int n_checks = 0;
    localparam logic [3:0] S_ROM = 4'h8;
    localparam logic [3:0] S_RAM = 4'h4;
    localparam logic [3:0] S_EXT = 4'h2;
    localparam logic [3:0] S_PER = 4'h1;

    always #20 core_clk = ~core_clk;

    ahb_master_model bus (.core_clk(core_clk), .req_master(req_master), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

    boot_remap_address_decoder uut (.core_clk(core_clk), .nrst(nrst),
        .boot_select_pin(boot_select_pin), .master_remap_bit(master_remap_bit),
        .instr_tcm_size(instr_tcm_size), .data_tcm_size(data_tcm_size),
        .req_master(req_master),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
        .hrdata(hrdata), .hready(hready), .hresp(hresp), .sel_rom(sel_rom),
        .sel_sram(sel_sram), .sel_ext(sel_ext), .sel_periph(sel_periph),
        .ext_chip_select(ext_chip_select), .slave_addr(slave_addr),
        .boot_from_rom(boot_from_rom));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, counts and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // reset with a given strap level held well before release
    task automatic do_reset(input logic strap);
        @(posedge core_clk);
        nrst <= 1'b0;
        boot_select_pin <= strap;
        master_remap_bit <= 6'h00;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(boot_from_rom, strap);
    endtask

    // one transfer: selects in address phase, response and data after
    task automatic acc(input logic [2:0] m, input logic [31:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] es, input logic [2:0] cs);
        bus.start(m, a, w);
        @(negedge core_clk);
        chk({sel_rom, sel_sram, sel_ext, sel_periph}, es);
        chk(slave_addr, a);
        if (es == S_EXT) begin
            chk(ext_chip_select, cs);
        end
        bus.finish(d);
        @(negedge core_clk);
        chk({hready, hresp}, (es == 4'h0) ? 3'b001 : 3'b100);
        if (es == S_RAM && !w) begin
            chk(hrdata, d);
        end
        if (es == 4'h0) begin
            @(negedge core_clk);
            chk({hready, hresp}, 3'b101);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        do_reset(1'b1);
        acc(4, 32'h0000_0000, 0, 0, S_ROM, 0);
        acc(0, 32'h0040_0000, 0, 0, S_ROM, 0);
        acc(0, 32'h0030_C000, 1, 32'h1234_5678, S_RAM, 0);
        acc(1, 32'h0030_C000, 0, 32'h1234_5678, S_RAM, 0);
        acc(0, 32'h0050_0000, 0, 0, 4'h0, 0);
        $display("test boot rom done");
        for (int b = 1; b < 16; b++) begin
            acc(3, {4'(b), 28'h000_0000}, 0, 0, (b <= 8) ? S_EXT : (b == 15) ? S_PER : 4'h0,
                (b > 6) ? 3'h5 : 3'(b - 1));
        end
        $display("test banks done");
        @(posedge core_clk);
        instr_tcm_size <= TCM_32K;
        data_tcm_size <= TCM_16K;
        acc(5, 32'h0010_4000, 0, 32'h1234_5678, S_RAM, 0);
        acc(2, 32'h0020_0000, 1, 32'hA5A5_0001, S_RAM, 0);
        acc(2, 32'h0030_4000, 0, 0, 4'h0, 0);
        @(posedge core_clk);
        instr_tcm_size <= TCM_16K;
        data_tcm_size <= TCM_0K;
        acc(3, 32'h0030_8000, 0, 32'h1234_5678, S_RAM, 0);
        acc(3, 32'h0030_0000, 0, 32'hA5A5_0001, S_RAM, 0);
        @(posedge core_clk);
        instr_tcm_size <= TCM_0K;
        data_tcm_size <= TCM_0K;
        acc(0, 32'h0030_0000, 0, 32'hA5A5_0001, S_RAM, 0);
        $display("test sram blocks done");
        @(posedge core_clk);
        master_remap_bit <= 6'h21;
        acc(5, 32'h0000_0000, 0, 32'hA5A5_0001, S_RAM, 0);
        acc(0, 32'h0000_0000, 0, 0, 4'h0, 0);
        acc(4, 32'h0000_0000, 0, 0, S_ROM, 0);
        acc(5, 32'h0040_0000, 0, 0, S_ROM, 0);
        $display("test remap done");
        do_reset(1'b0);
        acc(4, 32'h0000_0000, 0, 0, S_EXT, 0);
        $display("test external boot done");
        test_done();
    end

    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule
